// file: hw/ubg_top.sv
// Summary of operation
// - An internal 8-bit baud counter clocks UART modes 1 and 3 without any timer.
// - The counter counts up and reloads from the reload register instead of wrapping.
// - On overflow the counter takes the current reload value in the same cycle.
// - The counter advances only while the run bit is set.
// - The fast bit picks the undivided clock, otherwise the clock divided by six.
// - The only prescaler is the slow-mode divide by six, and the doubler bit scales the output rate.
// - Rate is 2^doubler/32 * fsys/(256-reload), divided by six when slow.
// - Transmit and receive each select the internal counter or a timer overflow.
// - An internal-counter select overrides the timer 2 select for that direction.
// - The receiver flags a missing stop bit by setting the frame fault flag.
// - Serial control bit 7 shows the fault flag when view select is 1, else mode bit 0.
// - The fault flag stays set until software writes it to zero.
// - A framing error sets the flag whatever the view select bit.
// - With the internal select clear, timer 2 is used if selected, else timer 1.
//
// The AHB-Lite interface to the registers is this design's own decision.
module ubg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic mode0_default_tick,
  input wire logic rx_stop_sample,
  input wire logic rx_stop_bit,
  output ubg_pkg::ubg_ticks_t bit_tick,
  output logic [1:0] tx_rate_shift,
  output logic serial_mode_bit_zero,
  output logic irq
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic ph_valid;
  logic ph_write;
  logic [9:0] ph_addr;
  logic [7:0] baud_reload_value;
  ubg_pkg::ubg_ctrl_t baud_control_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] power_control_reg;
  logic [7:0] timer2_control_reg;
  logic frame_fault_flag;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] internal_baud_counter;
  logic [2:0] slow_div;
  logic inc_en;
  logic ovf;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic [1:0] irq_events;
  logic framing_error;
  logic [7:0] serial_control_reg_view;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ph_valid && ph_write;
  assign rd_en = ph_valid && !ph_write;
  assign wbyte = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 10'h000;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1] && (hsize == 3'h2);
      ph_write <= hwrite;
      ph_addr <= haddr[9:0];
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_reload_value <= ubg_pkg::RST_BAUD_RELOAD;
      baud_control_reg <= ubg_pkg::RST_BAUD_CONTROL;
      serial_control_reg <= ubg_pkg::RST_BYTE;
      power_control_reg <= ubg_pkg::RST_BYTE;
      timer2_control_reg <= ubg_pkg::RST_BYTE;
      irq_mask <= ubg_pkg::RST_IRQ;
    end else if (wr_en) begin
      unique case (ph_addr)
        ubg_pkg::ADDR_BAUD_RELOAD: baud_reload_value <= wbyte;
        ubg_pkg::ADDR_BAUD_CONTROL: baud_control_reg <= wbyte[4:0];
        ubg_pkg::ADDR_POWER_CONTROL: power_control_reg <= wbyte;
        ubg_pkg::ADDR_TIMER2_CONTROL: timer2_control_reg <= wbyte;
        ubg_pkg::ADDR_IRQ_MASK: irq_mask <= wbyte[1:0];
        ubg_pkg::ADDR_SERIAL_CONTROL: begin
          // Bit 7 write goes to mode bit only in mode view
          if (power_control_reg[ubg_pkg::BIT_VIEW_SEL]) begin
            serial_control_reg <= {serial_control_reg[7], wbyte[6:0]};
          end else begin
            serial_control_reg <= wbyte;
          end
        end
        default: ;
      endcase
    end
  end

  assign serial_mode_bit_zero = serial_control_reg[ubg_pkg::BIT_SCON7];

  // ****************************************
  // Baud counter
  // ****************************************
  // Divide-by-six prescale in slow mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_div <= 3'h0;
    end else if (!baud_control_reg.baud_run || slow_div == ubg_pkg::SLOW_DIV_LAST) begin
      slow_div <= 3'h0;
    end else begin
      slow_div <= slow_div + 3'h1;
    end
  end

  assign inc_en = baud_control_reg.baud_run &&
                  (baud_control_reg.fast || slow_div == ubg_pkg::SLOW_DIV_LAST);
  assign ovf = inc_en && (internal_baud_counter == ubg_pkg::COUNT_TOP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_baud_counter <= ubg_pkg::RST_BAUD_RELOAD;
    end else if (ovf) begin
      internal_baud_counter <= baud_reload_value;
    end else if (inc_en) begin
      internal_baud_counter <= internal_baud_counter + 8'h01;
    end
  end

  // ****************************************
  // Tick routing
  // ****************************************
  // Per-direction source select
  // Timer 2 if selected, else timer 1
  // Counter drives modes 1 and 3
  always_comb begin
    bit_tick.tx = baud_control_reg.tx_sel ? ovf :
                  (timer2_control_reg[ubg_pkg::BIT_T2_TX] ? timer2_ovf : timer1_ovf);
    bit_tick.rx = baud_control_reg.rx_sel ? ovf :
                  (timer2_control_reg[ubg_pkg::BIT_T2_RX] ? timer2_ovf : timer1_ovf);
    bit_tick.mode0 = baud_control_reg.mode0_sel ? ovf : mode0_default_tick;
  end

  // Doubler scales 32 down to 16
  // Bit period is 32 or 16 ticks
  assign tx_rate_shift = power_control_reg[ubg_pkg::BIT_DOUBLER] ? 2'h1 : 2'h0;

  // ****************************************
  // Framing check and interrupts
  // ****************************************
  // Missing stop bit
  assign framing_error = rx_stop_sample && !rx_stop_bit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_fault_flag <= 1'b0;
    end else if (framing_error) begin
      frame_fault_flag <= 1'b1;
    end else if (wr_en && ph_addr == ubg_pkg::ADDR_SERIAL_CONTROL &&
                 power_control_reg[ubg_pkg::BIT_VIEW_SEL] && !wbyte[7]) begin
      frame_fault_flag <= 1'b0;
    end
  end

  assign irq_events = {ovf, framing_error};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= ubg_pkg::RST_IRQ;
    end else if (rd_en && ph_addr == ubg_pkg::ADDR_IRQ_STATUS) begin
      irq_status <= irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Read data
  // ****************************************
  // Bit 7 view select
  assign serial_control_reg_view = {power_control_reg[ubg_pkg::BIT_VIEW_SEL] ? frame_fault_flag :
                      serial_control_reg[7], serial_control_reg[6:0]};

  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (ph_addr)
        ubg_pkg::ADDR_BAUD_RELOAD: hrdata[7:0] = baud_reload_value;
        ubg_pkg::ADDR_BAUD_CONTROL: hrdata[4:0] = baud_control_reg;
        ubg_pkg::ADDR_SERIAL_CONTROL: hrdata[7:0] = serial_control_reg_view;
        ubg_pkg::ADDR_POWER_CONTROL: hrdata[7:0] = power_control_reg;
        ubg_pkg::ADDR_TIMER2_CONTROL: hrdata[7:0] = timer2_control_reg;
        ubg_pkg::ADDR_IRQ_STATUS: hrdata[1:0] = irq_status;
        ubg_pkg::ADDR_IRQ_MASK: hrdata[1:0] = irq_mask;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_top_inc;
    inc_en && internal_baud_counter == 8'hFF;
  endsequence

  a_reload_on_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
    s_top_inc |=> internal_baud_counter == $past(baud_reload_value))
    else $error("counter did not reload");
  // Stopped over a whole cycle, so a run write at the first edge is excluded
  sequence s_stopped;
    !baud_control_reg.baud_run ##1 !baud_control_reg.baud_run;
  endsequence

  sequence s_fault_clear;
    wr_en && ph_addr == ubg_pkg::ADDR_SERIAL_CONTROL &&
      power_control_reg[ubg_pkg::BIT_VIEW_SEL] && !wbyte[7] && !framing_error;
  endsequence

  sequence s_fault_view_read;
    rd_en && ph_addr == ubg_pkg::ADDR_SERIAL_CONTROL && power_control_reg[ubg_pkg::BIT_VIEW_SEL];
  endsequence

  sequence s_mode_view_read;
    rd_en && ph_addr == ubg_pkg::ADDR_SERIAL_CONTROL && !power_control_reg[ubg_pkg::BIT_VIEW_SEL];
  endsequence

  a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stopped |-> $stable(internal_baud_counter))
    else $error("counter moved while stopped");
  a_count_up: assert property (@(posedge hclk) disable iff (!hresetn)
    inc_en && internal_baud_counter != 8'hFF |=>
      internal_baud_counter == $past(internal_baud_counter) + 8'h01)
    else $error("counter did not step");
  a_slow_six: assert property (@(posedge hclk) disable iff (!hresetn)
    inc_en && !baud_control_reg.fast && $stable(baud_control_reg) |=> !inc_en [*5])
    else $error("slow rate not six");
  a_tx_route: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_control_reg.tx_sel |-> bit_tick.tx == ovf)
    else $error("tx route wrong");
  a_rx_timer: assert property (@(posedge hclk) disable iff (!hresetn)
    !baud_control_reg.rx_sel && !timer2_control_reg[ubg_pkg::BIT_T2_RX] |->
      bit_tick.rx == timer1_ovf)
    else $error("rx timer route wrong");
  a_fault_set: assert property (@(posedge hclk) disable iff (!hresetn)
    framing_error |=> frame_fault_flag)
    else $error("fault not set");
  a_fault_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_fault_flag && !wr_en |=> frame_fault_flag)
    else $error("fault cleared by hardware");
  a_mode0_route: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_control_reg.mode0_sel && ovf |-> bit_tick.mode0)
    else $error("mode0 tick missing");

  a_fast_every: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_control_reg.baud_run && baud_control_reg.fast |-> inc_en)
    else $error("fast mode skipped a count");

  a_stop_no_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
    !baud_control_reg.baud_run |-> !ovf)
    else $error("overflow while stopped");

  a_ovf_at_top: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf |-> internal_baud_counter == ubg_pkg::COUNT_TOP && inc_en)
    else $error("overflow away from top");

  a_rx_route: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_control_reg.rx_sel |-> bit_tick.rx == ovf)
    else $error("rx route wrong");

  a_tx_timer2: assert property (@(posedge hclk) disable iff (!hresetn)
    !baud_control_reg.tx_sel && timer2_control_reg[ubg_pkg::BIT_T2_TX] |->
      bit_tick.tx == timer2_ovf)
    else $error("tx timer 2 route wrong");

  a_tx_timer1: assert property (@(posedge hclk) disable iff (!hresetn)
    !baud_control_reg.tx_sel && !timer2_control_reg[ubg_pkg::BIT_T2_TX] |->
      bit_tick.tx == timer1_ovf)
    else $error("tx timer 1 route wrong");

  a_rx_timer2: assert property (@(posedge hclk) disable iff (!hresetn)
    !baud_control_reg.rx_sel && timer2_control_reg[ubg_pkg::BIT_T2_RX] |->
      bit_tick.rx == timer2_ovf)
    else $error("rx timer 2 route wrong");

  a_mode0_default: assert property (@(posedge hclk) disable iff (!hresetn)
    !baud_control_reg.mode0_sel |-> bit_tick.mode0 == mode0_default_tick)
    else $error("mode0 default route wrong");

  a_doubler_on: assert property (@(posedge hclk) disable iff (!hresetn)
    power_control_reg[ubg_pkg::BIT_DOUBLER] |-> tx_rate_shift == 2'h1)
    else $error("doubler not applied");

  a_doubler_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !power_control_reg[ubg_pkg::BIT_DOUBLER] |-> tx_rate_shift == 2'h0)
    else $error("rate scaled without doubler");

  a_view_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    s_fault_view_read |-> hrdata[7] == frame_fault_flag)
    else $error("fault view shows wrong bit");

  a_view_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    s_mode_view_read |-> hrdata[7] == serial_control_reg[7])
    else $error("mode view shows wrong bit");

  a_fault_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    s_fault_clear |=> !frame_fault_flag)
    else $error("software clear lost");

  a_frame_status: assert property (@(posedge hclk) disable iff (!hresetn)
    framing_error |=> irq_status[ubg_pkg::BIT_IRQ_FRAME])
    else $error("frame event not in status");

  a_ovf_status: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf |=> irq_status[ubg_pkg::BIT_IRQ_OVF])
    else $error("overflow event not in status");
endmodule

// file: hw/ubg_pkg.sv
package ubg_pkg;
  // ****************************************
  // Register map (byte addresses, printed offsets are not all multiples of four)
  // ****************************************
  localparam logic [7:0] IDX_BAUD_RELOAD = 8'h9A;
  localparam logic [7:0] IDX_BAUD_CONTROL = 8'h9B;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_TIMER2_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;
  localparam logic [9:0] ADDR_BAUD_RELOAD = {IDX_BAUD_RELOAD, 2'b00};
  localparam logic [9:0] ADDR_BAUD_CONTROL = {IDX_BAUD_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_SERIAL_CONTROL = {IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_POWER_CONTROL = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_TIMER2_CONTROL = {IDX_TIMER2_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_BAUD_RUN = 4;
  localparam int BIT_TX_SEL = 3;
  localparam int BIT_RX_SEL = 2;
  localparam int BIT_FAST = 1;
  localparam int BIT_MODE0_SEL = 0;
  localparam int BIT_DOUBLER = 7;
  localparam int BIT_VIEW_SEL = 6;
  localparam int BIT_SCON7 = 7;
  localparam int BIT_T2_TX = 4;
  localparam int BIT_T2_RX = 5;
  localparam int BIT_IRQ_FRAME = 0;
  localparam int BIT_IRQ_OVF = 1;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] RST_BAUD_RELOAD = 8'h00;
  localparam logic [4:0] RST_BAUD_CONTROL = 5'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [2:0] SLOW_DIV_LAST = 3'h5;
  localparam logic [7:0] COUNT_TOP = 8'hFF;

  typedef enum logic [1:0] {
    UBG_IDLE = 2'b00,
    UBG_DATA = 2'b01
  } ubg_phase_t;

  typedef struct packed {
    logic tx;
    logic rx;
    logic mode0;
  } ubg_ticks_t;

  typedef struct packed {
    logic baud_run;
    logic tx_sel;
    logic rx_sel;
    logic fast;
    logic mode0_sel;
  } ubg_ctrl_t;
endpackage

// file: tb/ubg_far_tx.sv
// ****************************************
// Remote transmitter: stop bit per frame
// ****************************************
module ubg_far_tx (
  input wire logic hclk,
  output logic rx_stop_sample,
  output logic rx_stop_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_stop_sample = 1'b0;
    rx_stop_bit = 1'b0;
  end
  // Unsampled line carries no stale level
  always @(negedge hclk) begin
    if (!rx_stop_sample) begin
      rx_stop_bit <= ~rx_stop_bit;
    end
  end
  // Idle span sets prompt or slow delivery
  task automatic frame(input logic stop_ok, input int idle);
    repeat (idle) @(posedge hclk);
    rx_stop_sample <= 1'b1;
    rx_stop_bit <= stop_ok;
    @(posedge hclk);
    rx_stop_sample <= 1'b0;
  endtask
endmodule

// file: tb/test_uart_baud_gen_framing_check.sv
module test_uart_baud_gen_framing_check;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A_RL = ubg_pkg::ADDR_BAUD_RELOAD;
  localparam logic [9:0] A_CT = ubg_pkg::ADDR_BAUD_CONTROL;
  localparam logic [9:0] A_SC = ubg_pkg::ADDR_SERIAL_CONTROL;
  localparam logic [9:0] A_PC = ubg_pkg::ADDR_POWER_CONTROL;
  localparam logic [9:0] A_T2 = ubg_pkg::ADDR_TIMER2_CONTROL;
  localparam logic [9:0] A_ST = ubg_pkg::ADDR_IRQ_STATUS;
  localparam logic [9:0] A_MK = ubg_pkg::ADDR_IRQ_MASK;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_phase;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, tx_rate_shift;
  logic [2:0] hsize;
  logic timer1_ovf, timer2_ovf, mode0_default_tick, rx_stop_sample, rx_stop_bit;
  logic serial_mode_bit_zero, irq;
  logic [7:0] r;
  ubg_pkg::ubg_ticks_t bit_tick;
  logic [31:0] exp_q[$];
  int bad_count = 0, total_checks = 0, old_n;
  int cnt[3] = '{0, 0, 0}, gap[3] = '{0, 0, 0}, n[3] = '{0, 0, 0};

  ubg_top ubg_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer1_ovf(timer1_ovf),
    .timer2_ovf(timer2_ovf), .mode0_default_tick(mode0_default_tick),
    .rx_stop_sample(rx_stop_sample), .rx_stop_bit(rx_stop_bit), .bit_tick(bit_tick),
    .tx_rate_shift(tx_rate_shift), .serial_mode_bit_zero(serial_mode_bit_zero), .irq(irq));
  ubg_far_tx ubg_far_tx_inst (.hclk(hclk), .rx_stop_sample(rx_stop_sample),
    .rx_stop_bit(rx_stop_bit));

  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_phase <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
    hsel <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Monitors and free-running stimulus
  // ****************************************
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) chk(exp_q.pop_front(), hrdata);
  end
  always @(posedge hclk) begin
    for (int i = 0; i < 3; i++) begin
      if (bit_tick[i] === 1'b1) begin
        gap[i] <= cnt[i] + 1;
        cnt[i] <= 0;
        n[i] <= n[i] + 1;
      end else cnt[i] <= cnt[i] + 1;
    end
  end
  always @(posedge hclk) {timer1_ovf, timer2_ovf, mode0_default_tick} <= 3'($urandom);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    #240000;
    bad_count++;
    print_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {hresetn, hsel, hwrite, rd_phase, timer1_ovf, timer2_ovf, mode0_default_tick} = 7'h0;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    void'($urandom(58));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_RL, 32'h0);
    rd(A_CT, 32'h0);
    rd(A_ST, 32'h0);
    r = 8'($urandom);
    xfer(1'b1, A_RL, {24'h0, r});
    rd(A_RL, {24'h0, r});
    xfer(1'b1, 10'h3FC, 32'hFF);
    rd(10'h3FC, 32'h0);
    $display("test registers done");
    xfer(1'b1, A_SC, 32'h80);
    xfer(1'b1, A_MK, 32'h01);
    ubg_far_tx_inst.frame(1'b1, 0);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    ubg_far_tx_inst.frame(1'b0, 5);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b1);
    chk(serial_mode_bit_zero, 1'b1);
    rd(A_SC, 32'h80);
    xfer(1'b1, A_PC, 32'h40);
    rd(A_ST, 32'h01);
    @(negedge hclk);
    chk(irq, 1'b0);
    rd(A_ST, 32'h0);
    ubg_far_tx_inst.frame(1'b1, 2);
    rd(A_SC, 32'h80);
    xfer(1'b1, A_SC, 32'h00);
    rd(A_SC, 32'h00);
    chk(serial_mode_bit_zero, 1'b1);
    xfer(1'b1, A_MK, 32'h0);
    ubg_far_tx_inst.frame(1'b0, 1);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    rd(A_ST, 32'h01);
    xfer(1'b1, A_PC, 32'h80);
    @(negedge hclk);
    chk(tx_rate_shift, 2'h1);
    xfer(1'b1, A_PC, 32'h00);
    @(negedge hclk);
    chk(tx_rate_shift, 2'h0);
    $display("test framing done");
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, A_CT, 32'(i[1:0]) << 2);
      xfer(1'b1, A_T2, 32'(i[3:2]) << 4);
      repeat (8) begin
        @(negedge hclk);
        chk({29'h0, bit_tick}, {29'h0, !i[1] && (i[2] ? timer2_ovf : timer1_ovf),
          !i[0] && (i[3] ? timer2_ovf : timer1_ovf), mode0_default_tick});
      end
    end
    $display("test routing done");
    xfer(1'b1, A_T2, 32'h0);
    r = 8'hF0 | 8'($urandom % 16);
    xfer(1'b1, A_RL, {24'h0, r});
    xfer(1'b1, A_CT, 32'h1B);
    repeat (300) @(posedge hclk);
    @(negedge hclk);
    chk(gap[2], 256 - r);
    chk(gap[0], 256 - r);
    xfer(1'b1, A_RL, 32'hFE);
    xfer(1'b1, A_CT, 32'h1C);
    repeat (1700) @(posedge hclk);
    @(negedge hclk);
    chk(gap[2], 12);
    chk(gap[1], 12);
    xfer(1'b1, A_CT, 32'h0A);
    @(negedge hclk);
    old_n = n[2];
    repeat (100) @(posedge hclk);
    chk(n[2], old_n);
    $display("test counter done");
    print_verdict();
  end
endmodule
